/* File: rtl/ctp_pkg.sv */
/*
 * Shared definitions for the cascaded timer, carrier generator and PWM block:
 * mode encodings, control byte layout, clock-select codes and reset values.
 * Assumes one core clock that is also the main oscillator for the count clock.
 */
// Function
// - Upper count byte is the high byte, lower count byte the low byte.
// - In cascade mode only the lower run bit starts and clears the count.
// - Full match of both bytes clears both together; counting continues.
// - Full match pulses only the lower match interrupt, never the upper one.
// - Interval is 256 times upper compare plus lower compare plus one ticks.
// - Clock select 000 full, 001 quarter, 010 half, 011 quarter, 100 eighth, 101 sixteenth.
// - Cascade square wave toggles the output on every full match.
// - Clearing the lower run bit forces the square wave output low.
// - Output pin starts low when the output gate is enabled, except in carrier mode with remote select and active envelope both set.
// - Carrier: lower match pulses lower irq, toggles carrier, swaps compare.
// - Carrier: upper match pulses upper irq and loads active from buffer bit.
// - Carrier: carrier clock drives the pin while the active envelope bit is one and remote select is zero.
// - Control byte: bit 0 active envelope, bit 1 buffer, bit 2 remote select.
// - Active envelope bit is writable only while the output gate is off.
// - Buffer bit is lost on carrier stop; software reloads it before restart.
// - PWM low width follows low-phase compare, high width high-phase compare.
// - PWM match pulses irq, toggles output, swaps compare, clears lower count.
package ctp_pkg;

    // ----------------------------------------------------------------
    // Operating modes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        CTP_MODE_CASCADE = 3'b001,
        CTP_MODE_CARRIER = 3'b010,
        CTP_MODE_PWM = 3'b100
    } ctp_mode_type;

    // ----------------------------------------------------------------
    // Control byte layout
    // ----------------------------------------------------------------
    localparam int CTP_ACTIVE_BIT = 0;
    localparam int CTP_BUFFER_BIT = 1;
    localparam int CTP_REMOTE_BIT = 2;
    localparam logic [4:0] CTP_CTRL_PAD = 5'h00;

    // ----------------------------------------------------------------
    // Clock select codes
    // ----------------------------------------------------------------
    localparam logic [2:0] CTP_SEL_DIV1 = 3'h0;
    localparam logic [2:0] CTP_SEL_DIV4A = 3'h1;
    localparam logic [2:0] CTP_SEL_DIV2 = 3'h2;
    localparam logic [2:0] CTP_SEL_DIV4B = 3'h3;
    localparam logic [2:0] CTP_SEL_DIV8 = 3'h4;
    localparam logic [2:0] CTP_SEL_DIV16 = 3'h5;

    // ----------------------------------------------------------------
    // Reset values and counts
    // ----------------------------------------------------------------
    localparam logic [7:0] CTP_BYTE_ZERO = 8'h00;
    localparam logic [7:0] CTP_BYTE_MAX = 8'hff;
    localparam logic [3:0] CTP_DIV_ZERO = 4'h0;
    localparam logic [3:0] CTP_DIV_STEP = 4'h1;
    localparam logic [7:0] CTP_BYTE_STEP = 8'h01;

    // Settings carried into the core as one bundle
    typedef struct packed {
        ctp_mode_type mode;
        logic [2:0] clk_sel;
        logic lower_run;
        logic upper_run;
        logic gate;
    } ctp_cfg_type;

endpackage

/* File: rtl/ctp_timer.sv */
/*
 * Cascaded pair of 8-bit timers with 16-bit interval and square-wave,
 * carrier generator with envelope gating, and PWM output.
 * Assumes all inputs are synchronous to CORE_CLK, which is the main
 * oscillator; compares and mode are static while the timer runs.
 */
`timescale 1ns/1ps
module ctp_timer (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // Configuration
    input wire logic [1:0] MODE_SEL,
    input wire logic [2:0] CLOCK_SELECT,
    input wire logic LOWER_RUN_BIT,
    input wire logic UPPER_RUN_BIT,
    input wire logic OUTPUT_GATE_ENABLE,
    // Compare values
    input wire logic [7:0] UPPER_COMPARE,
    input wire logic [7:0] LOW_PHASE_COMPARE,
    input wire logic [7:0] HIGH_PHASE_COMPARE,
    // Carrier output control byte
    input wire logic CTRL_WR,
    input wire logic [7:0] CTRL_WDATA,
    output logic [7:0] CTRL_RDATA,
    // Status
    output logic [7:0] UPPER_COUNT_BYTE,
    output logic [7:0] LOWER_COUNT_BYTE,
    // Events and pin
    output logic UPPER_MATCH_IRQ,
    output logic LOWER_MATCH_IRQ,
    output logic TIMER_OUTPUT_PIN
);
    import ctp_pkg::*;

    // ----------------------------------------------------------------
    // Count clock decode
    // ----------------------------------------------------------------
    function automatic logic clk_tick(input logic [2:0] sel, input logic [3:0] div);
        logic t;
        t = 1'b0;
        case (sel)
            CTP_SEL_DIV1: t = 1'b1;
            CTP_SEL_DIV2: t = div[0];
            CTP_SEL_DIV4A: t = &div[1:0];
            CTP_SEL_DIV4B: t = &div[1:0];
            CTP_SEL_DIV8: t = &div[2:0];
            CTP_SEL_DIV16: t = &div;
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    // ----------------------------------------------------------------
    // Compare decode
    // ----------------------------------------------------------------
    // Shared by every match term so all compares agree
    function automatic logic byte_hit(input logic [7:0] count, input logic [7:0] cmp);
        return (count == cmp);
    endfunction

    // ----------------------------------------------------------------
    // Configuration bundle
    // ----------------------------------------------------------------
    ctp_cfg_type cfg;
    ctp_mode_type mode_dec;

    // Code 11 falls back to cascade
    always_comb begin
        case (MODE_SEL)
            2'b01: mode_dec = CTP_MODE_CARRIER;
            2'b10: mode_dec = CTP_MODE_PWM;
            default: mode_dec = CTP_MODE_CASCADE;
        endcase
    end

    // One driver for the whole bundle keeps it a single variable
    assign cfg = '{
        mode: mode_dec,
        clk_sel: CLOCK_SELECT,
        lower_run: LOWER_RUN_BIT,
        upper_run: UPPER_RUN_BIT,
        gate: OUTPUT_GATE_ENABLE
    };

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [3:0] div_q;
    logic [7:0] lower_q;
    logic [7:0] upper_q;
    logic phase_q;
    logic wave_q;
    logic act_q;
    logic buf_q;
    logic rmt_q;
    logic run_prev_q;
    logic upper_irq_q;
    logic lower_irq_q;
    logic out_q;
    logic out_d;

    logic tick;
    logic cascade;
    logic carrier;
    logic pwm;
    logic [7:0] phase_cmp;
    logic full_match;
    logic lower_match;
    logic upper_match;
    logic upper_step;
    logic lower_event;
    logic upper_event;

    assign cascade = (cfg.mode == CTP_MODE_CASCADE);
    assign carrier = (cfg.mode == CTP_MODE_CARRIER);
    assign pwm = (cfg.mode == CTP_MODE_PWM);

    // ----------------------------------------------------------------
    // Prescaler
    // ----------------------------------------------------------------
    // Free running so the selected rate is a single enable pulse.
    // Not restarted by run: first tick may come up to divider-1 cycles late.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            div_q <= CTP_DIV_ZERO;
        end else begin
            div_q <= div_q + CTP_DIV_STEP;
        end
    end

    // Codes 110 and 111 give no tick, so the counters hold
    assign tick = clk_tick(cfg.clk_sel, div_q);

    // ----------------------------------------------------------------
    // Match detection
    // ----------------------------------------------------------------
    assign phase_cmp = phase_q ? HIGH_PHASE_COMPARE : LOW_PHASE_COMPARE;

    // Both bytes must match in the same tick
    assign full_match = byte_hit(lower_q, LOW_PHASE_COMPARE) &&
                        byte_hit(upper_q, UPPER_COMPARE);
    assign lower_match = byte_hit(lower_q, phase_cmp);
    assign upper_match = byte_hit(upper_q, UPPER_COMPARE);

    // Upper timer counts carrier half periods in carrier mode
    assign upper_step = carrier && cfg.upper_run && lower_match;

    assign lower_event = cfg.lower_run && tick &&
                         (cascade ? full_match : lower_match);
    // Needs a tick so a held match cannot fire twice
    assign upper_event = cfg.lower_run && tick && upper_step && upper_match;

    // ----------------------------------------------------------------
    // Lower count byte
    // ----------------------------------------------------------------
    // Clears on stop so a restart always begins at zero
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            lower_q <= CTP_BYTE_ZERO;
        end else if (!cfg.lower_run) begin
            lower_q <= CTP_BYTE_ZERO;
        end else if (tick) begin
            if (lower_event) begin
                lower_q <= CTP_BYTE_ZERO;
            end else begin
                lower_q <= lower_q + CTP_BYTE_STEP;
            end
        end
    end

    // ----------------------------------------------------------------
    // Upper count byte
    // ----------------------------------------------------------------
    // Upper run bit is ignored while cascaded.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            upper_q <= CTP_BYTE_ZERO;
        end else if (cascade) begin
            if (!cfg.lower_run) begin
                upper_q <= CTP_BYTE_ZERO;
            end else if (tick) begin
                if (full_match) begin
                    upper_q <= CTP_BYTE_ZERO;
                end else if (lower_q == CTP_BYTE_MAX) begin
                    upper_q <= upper_q + CTP_BYTE_STEP;
                end
            end
        end else if (carrier) begin
            if (!cfg.upper_run || !cfg.lower_run) begin
                upper_q <= CTP_BYTE_ZERO;
            end else if (tick && upper_step) begin
                if (upper_match) begin
                    upper_q <= CTP_BYTE_ZERO;
                end else begin
                    upper_q <= upper_q + CTP_BYTE_STEP;
                end
            end
        end else begin
            upper_q <= CTP_BYTE_ZERO;
        end
    end

    // ----------------------------------------------------------------
    // Compare phase select
    // ----------------------------------------------------------------
    // Each run restarts on the low-phase compare
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            phase_q <= 1'b0;
        end else if (!cfg.lower_run || cascade) begin
            phase_q <= 1'b0;
        end else if (lower_event) begin
            phase_q <= ~phase_q;
        end
    end

    // ----------------------------------------------------------------
    // Wave toggle flip-flop
    // ----------------------------------------------------------------
    // Held low while stopped or gated off so each enable starts low.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            wave_q <= 1'b0;
        end else if (!cfg.lower_run) begin
            wave_q <= 1'b0;
        end else if (!cfg.gate) begin
            wave_q <= 1'b0;
        end else if (lower_event) begin
            wave_q <= ~wave_q;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt pulses
    // ----------------------------------------------------------------
    // Registered so each event gives exactly one cycle pulse
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            lower_irq_q <= 1'b0;
        end else begin
            lower_irq_q <= lower_event;
        end
    end

    // Never raised by a cascaded full match
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            upper_irq_q <= 1'b0;
        end else begin
            upper_irq_q <= upper_event;
        end
    end

    // ----------------------------------------------------------------
    // Carrier output control byte
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            run_prev_q <= 1'b0;
        end else begin
            run_prev_q <= cfg.lower_run;
        end
    end

    // Reload on the upper event wins over a software write.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            act_q <= 1'b0;
        end else if (upper_event) begin
            act_q <= buf_q;
        end else if (CTRL_WR && !cfg.gate) begin
            act_q <= CTRL_WDATA[CTP_ACTIVE_BIT];
        end
    end

    // Buffer is dropped when the carrier stops; a write in that cycle wins.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            buf_q <= 1'b0;
        end else if (CTRL_WR) begin
            buf_q <= CTRL_WDATA[CTP_BUFFER_BIT];
        end else if (carrier && run_prev_q && !cfg.lower_run) begin
            buf_q <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            rmt_q <= 1'b0;
        end else if (CTRL_WR) begin
            rmt_q <= CTRL_WDATA[CTP_REMOTE_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Output pin
    // ----------------------------------------------------------------
    // Remote select shows the raw envelope level instead of the carrier
    always_comb begin
        out_d = 1'b0;
        case (cfg.mode)
            CTP_MODE_CASCADE: out_d = wave_q;
            CTP_MODE_PWM: out_d = wave_q;
            CTP_MODE_CARRIER: begin
                if (!act_q) begin
                    out_d = 1'b0;
                end else if (rmt_q) begin
                    out_d = 1'b1;
                end else begin
                    out_d = wave_q;
                end
            end
            default: out_d = 1'b0;
        endcase
    end

    // Registered so the pin never glitches on mode changes
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            out_q <= 1'b0;
        end else if (!cfg.gate) begin
            out_q <= 1'b0;
        end else begin
            out_q <= out_d;
        end
    end

    // ----------------------------------------------------------------
    // Port drive
    // ----------------------------------------------------------------
    assign CTRL_RDATA = {CTP_CTRL_PAD, rmt_q, buf_q, act_q};
    assign UPPER_COUNT_BYTE = upper_q;
    assign LOWER_COUNT_BYTE = lower_q;
    assign UPPER_MATCH_IRQ = upper_irq_q;
    assign LOWER_MATCH_IRQ = lower_irq_q;
    assign TIMER_OUTPUT_PIN = out_q;

endmodule // ctp_timer

/* File: verification/ctp_checker.sv */
/* Concurrent checks on the ctp_timer ports, attached by bind.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module ctp_checker (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // Configuration
    input wire logic [1:0] MODE_SEL,
    input wire logic [2:0] CLOCK_SELECT,
    input wire logic LOWER_RUN_BIT,
    input wire logic OUTPUT_GATE_ENABLE,
    input wire logic [7:0] UPPER_COMPARE,
    input wire logic [7:0] LOW_PHASE_COMPARE,
    // Control byte
    input wire logic CTRL_WR,
    input wire logic [7:0] CTRL_WDATA,
    input wire logic [7:0] CTRL_RDATA,
    // Outputs
    input wire logic [7:0] UPPER_COUNT_BYTE,
    input wire logic [7:0] LOWER_COUNT_BYTE,
    input wire logic UPPER_MATCH_IRQ,
    input wire logic LOWER_MATCH_IRQ,
    input wire logic TIMER_OUTPUT_PIN
);
    wire logic casc = MODE_SEL[0] ~^ MODE_SEL[1];
    wire logic carr = MODE_SEL == 2'h1;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // ----------------------------------------------------------------
    // Full match on an undivided tick
    // ----------------------------------------------------------------
    sequence s_full;
        casc && LOWER_RUN_BIT && CLOCK_SELECT == 3'h0 &&
            {UPPER_COUNT_BYTE, LOWER_COUNT_BYTE} == {UPPER_COMPARE, LOW_PHASE_COMPARE};
    endsequence
    AST_FULL_CLEAR: assert property (s_full |=> {UPPER_COUNT_BYTE, LOWER_COUNT_BYTE} == 16'h0)
        else $error("count not cleared");
    AST_LOWER_ONLY: assert property (s_full |=> LOWER_MATCH_IRQ && !UPPER_MATCH_IRQ)
        else $error("wrong match interrupt");
    AST_TOGGLE: assert property (s_full ##0 OUTPUT_GATE_ENABLE ##1
        (casc && OUTPUT_GATE_ENABLE) |=> TIMER_OUTPUT_PIN != $past(TIMER_OUTPUT_PIN))
        else $error("pin did not toggle");
    AST_RUN_CLEAR: assert property (!LOWER_RUN_BIT |=> LOWER_COUNT_BYTE == 8'h00)
        else $error("stopped count not clear");
    AST_WAVE_STOP: assert property ((!LOWER_RUN_BIT && !carr) [*2] |=> !TIMER_OUTPUT_PIN)
        else $error("wave not forced low");
    AST_GATE_LOW: assert property (!OUTPUT_GATE_ENABLE [*2] |=> !TIMER_OUTPUT_PIN)
        else $error("pin high with gate off");
    AST_CTRL_WRITE: assert property (CTRL_WR |=> CTRL_RDATA[7:1] == {5'h00, $past(CTRL_WDATA[2:1])})
        else $error("control byte fields");
    AST_ACTIVE_HOLD: assert property (CTRL_WR && OUTPUT_GATE_ENABLE |=>
        ($stable(CTRL_RDATA[0]) || UPPER_MATCH_IRQ)) else $error("active bit written");
    AST_RELOAD: assert property ($rose(UPPER_MATCH_IRQ) && OUTPUT_GATE_ENABLE |->
        CTRL_RDATA[0] == $past(CTRL_RDATA[1])) else $error("envelope not reloaded");
    AST_ENV_LOW: assert property ((carr && !CTRL_RDATA[0]) [*2] |=> !TIMER_OUTPUT_PIN)
        else $error("pin high with envelope off");
endmodule // ctp_checker

bind ctp_timer ctp_checker u_checker (.CORE_CLK, .RST, .MODE_SEL, .CLOCK_SELECT, .LOWER_RUN_BIT,
    .OUTPUT_GATE_ENABLE, .UPPER_COMPARE, .LOW_PHASE_COMPARE, .CTRL_WR, .CTRL_WDATA, .CTRL_RDATA,
    .UPPER_COUNT_BYTE, .LOWER_COUNT_BYTE, .UPPER_MATCH_IRQ, .LOWER_MATCH_IRQ, .TIMER_OUTPUT_PIN);

/* File: verification/ctp_pin_load.sv */
/* Passive load on the timer output pin: measures high and low widths.
   Assumes the pin is sampled on the core clock; it drives nothing back. */
`timescale 1ns/1ps
module ctp_pin_load (
    // Clock, reset, pin
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    // Widths in cycles and edge count
    output int high_width,
    output int low_width,
    output int edges
);
    logic last_q;
    int len_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            last_q <= 1'b0;
            len_q <= 1;
            edges <= 0;
        end else if (pin !== last_q) begin
            if (last_q) begin
                high_width <= len_q;
            end else begin
                low_width <= len_q;
            end
            len_q <= 1;
            edges <= edges + 1;
            last_q <= pin;
        end else begin
            len_q <= len_q + 1;
        end
    end
endmodule // ctp_pin_load

/* File: verification/cascaded_timer_carrier_pwm_tb_top.sv */
/* Bench for ctp_timer: cascade, clock select, PWM and carrier.
   Assumes the bound checker and the pin load model. */
`timescale 1ns/1ps
module cascaded_timer_carrier_pwm_tb_top;
    import ctp_pkg::*;
    logic clk = 1'b0, rst = 1'b1, run = 1'b0, urun = 1'b0, gate = 1'b0, wr = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [2:0] sel = 3'h0;
    logic [7:0] wdata = 8'h00, ucmp = 8'h00, lcmp = 8'h00, hcmp = 8'h00;
    logic [7:0] rdata, ucnt, lcnt;
    logic uirq, lirq, pin;
    int hi_w, lo_w, edges, n, e;
    int failures = 0;
    int checks = 0;
    int divs [6] = '{1, 4, 2, 4, 8, 16};
    ctp_timer dut (.CORE_CLK(clk), .RST(rst), .MODE_SEL(mode), .CLOCK_SELECT(sel),
        .LOWER_RUN_BIT(run), .UPPER_RUN_BIT(urun), .OUTPUT_GATE_ENABLE(gate),
        .UPPER_COMPARE(ucmp), .LOW_PHASE_COMPARE(lcmp), .HIGH_PHASE_COMPARE(hcmp),
        .CTRL_WR(wr), .CTRL_WDATA(wdata), .CTRL_RDATA(rdata), .UPPER_COUNT_BYTE(ucnt),
        .LOWER_COUNT_BYTE(lcnt), .UPPER_MATCH_IRQ(uirq), .LOWER_MATCH_IRQ(lirq),
        .TIMER_OUTPUT_PIN(pin));
    ctp_pin_load load (.clk(clk), .rst(rst), .pin(pin), .high_width(hi_w),
        .low_width(lo_w), .edges(edges));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic check(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic results;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Bounded wait for a match interrupt, cycles counted
    task automatic wait_irq(input logic up, output int k);
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while ((up ? uirq : lirq) !== 1'b1 && k < 5000);
        if (k >= 5000) begin
            failures++;
            $display("mismatch at %0t: interrupt timeout", $time);
            results();
        end
    endtask
    task automatic period(input int exp, input string msg);
        wait_irq(1'b0, n);
        wait_irq(1'b0, n);
        check(n == exp, msg);
    endtask
    // Stop, gate off, then clock, mode, compares
    task automatic setup(input logic [1:0] m, input logic [2:0] s, input logic [7:0] u, l, h);
        @(posedge clk);
        run <= 1'b0;
        urun <= 1'b0;
        gate <= 1'b0;
        @(posedge clk);
        sel <= s;
        mode <= m;
        ucmp <= u;
        lcmp <= l;
        hcmp <= h;
        @(posedge clk);
    endtask
    // Whole-byte write only; bit writes would race the reload
    task automatic ctrl(input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        cyc(20);
        rst <= 1'b0;
        setup(2'h0, 3'h0, 8'h01, 8'h02, 8'h00);
        gate <= 1'b1;
        cyc(2);
        @(negedge clk);
        check(pin === 1'b0, "pin high at gate on");
        @(posedge clk);
        run <= 1'b1;
        urun <= 1'b1;
        period(259, "16-bit interval");
        cyc(2);
        @(negedge clk);
        check(hi_w === 259, "square half period");
        wait_irq(1'b0, n);
        @(posedge clk);
        run <= 1'b0;
        cyc(2);
        @(negedge clk);
        check(pin === 1'b0 && {ucnt, lcnt} === 16'h0000, "stop");
        setup(2'h0, 3'h0, 8'h00, 8'h00, 8'h00);
        run <= 1'b1;
        period(1, "zero compare interval");
        $display("cascade test done");
        foreach (divs[i]) begin
            setup(2'h3, 3'(i), 8'h00, 8'h03, 8'h00);
            run <= 1'b1;
            period(4 * divs[i], "clock select period");
        end
        $display("clock select test done");
        setup(2'h2, 3'h0, 8'h00, 8'h02, 8'h05);
        gate <= 1'b1;
        @(posedge clk);
        run <= 1'b1;
        cyc(40);
        @(negedge clk);
        check(lo_w === 3 && hi_w === 6, "pwm widths");
        $display("pwm test done");
        setup(2'h1, 3'h0, 8'h03, 8'h01, 8'h01);
        ctrl(8'h06);
        @(negedge clk);
        check(rdata === 8'h06, "control fields");
        ctrl(8'h01);
        gate <= 1'b1;
        ctrl(8'h00);
        @(negedge clk);
        check(rdata === 8'h01, "active bit with gate on");
        @(posedge clk);
        run <= 1'b1;
        urun <= 1'b1;
        cyc(7);
        @(negedge clk);
        check(hi_w === 2, "carrier on pin");
        wait_irq(1'b1, n);
        ctrl(8'h00);
        cyc(3);
        @(negedge clk);
        e = edges;
        cyc(20);
        @(negedge clk);
        check(edges === e && pin === 1'b0 && rdata === 8'h00, "envelope off");
        @(posedge clk);
        gate <= 1'b0;
        ctrl(8'h07);
        gate <= 1'b1;
        cyc(20);
        @(negedge clk);
        check(pin === 1'b1 && rdata === 8'h07, "remote envelope level");
        @(posedge clk);
        run <= 1'b0;
        cyc(2);
        @(negedge clk);
        check(rdata === 8'h05, "buffer dropped on stop");
        $display("carrier test done");
        results();
    end
endmodule // cascaded_timer_carrier_pwm_tb_top
